//--- spl_pkg.sv
// constants shared by the serial port select and driver enable block
package spl_pkg;

  // ****************************************************************
  // sizes
  // ****************************************************************
  localparam int unsigned CHANNELS = 4;
  localparam int unsigned DRV_PER_CH = 2;
  localparam int unsigned EN_W = 8;
  localparam int unsigned AMP_W = 8;
  localparam int unsigned ADR_W = 8;
  localparam int unsigned DAT_W = 32;
  localparam int unsigned SEL_W = 4;

  // ****************************************************************
  // register map, byte offsets
  // ****************************************************************
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] ENBUS_OFF = 8'h04;
  localparam logic [7:0] STAT_OFF = 8'h08;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int unsigned CTRL_LOOP_BIT = 0;
  localparam int unsigned CTRL_SEL_LSB = 4;
  localparam int unsigned CTRL_OPEN_BIT = 8;
  localparam int unsigned CTRL_AMP_LSB = 9;
  localparam int unsigned STAT_VALID_LSB = 8;
  localparam int unsigned STAT_RST_BIT = 12;

  // ****************************************************************
  // three-level amplitude select and reset values
  // ****************************************************************
  typedef enum logic [1:0] {
    SPL_AMP_LOW = 2'b00,
    SPL_AMP_MID = 2'b01,
    SPL_AMP_HIGH = 2'b10
  } spl_amp_t;

  localparam logic [7:0] THR_LOW_DEF = 8'h20;
  localparam logic [7:0] THR_MID_DEF = 8'h40;
  localparam logic [7:0] THR_HIGH_DEF = 8'h80;
  localparam logic [3:0] SEL_RST = 4'hF;
  localparam logic [1:0] AMP_RST = 2'h1;
  localparam logic [7:0] ENBUS_RST = 8'h00;

endpackage

//--- spl_latch_if.sv
// carrier between the top and the driver enable latch
`timescale 1ns/100ps
interface spl_latch_if #(parameter int unsigned W = 8);
  logic open;
  logic clear;
  logic [W-1:0] bus;
  logic [W-1:0] held;
  modport ctl(output open, output clear, output bus, input held);
  modport latch(input open, input clear, input bus, output held);
endinterface

//--- spl_enable_latch.sv
// driver enable latch: transparent while open, holds when closed
`timescale 1ns/100ps
module spl_enable_latch (
  input wire logic clk_i,
  input wire logic rst_i,
  spl_latch_if.latch lat
);

  typedef struct packed {
    logic [spl_pkg::EN_W-1:0] held;
  } spl_lat_state_t;

  spl_lat_state_t s;
  spl_lat_state_t next_s;

  // clear beats open so a reset always powers every driver down
  always_comb begin
    next_s = s;
    if (lat.clear) begin
      next_s.held = '0; // see [R09]
    end else if (lat.open) begin
      next_s.held = lat.bus; // see [R06]
    end
    // closed: keep the last captured bus value, see [R08]
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign lat.held = s.held;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_latch_follows_open: assert property ( // see [R06]
    lat.open && !lat.clear |=> lat.held == $past(lat.bus))
    else $error("open latch did not follow the enable bus");

  a_latch_holds_closed: assert property ( // see [R08]
    !lat.open && !lat.clear |=> $stable(lat.held))
    else $error("closed latch changed its value");

  a_latch_clear: assert property ( // see [R09]
    lat.clear |=> lat.held == '0)
    else $error("device reset did not clear the latch");

endmodule

//--- spl_channel.sv
// one channel: receive input select, loopback and two drivers
`timescale 1ns/100ps
module spl_channel (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic input_select_i,
  input wire logic loopback_i,
  input wire logic [1:0] driver_enable_i,
  input wire logic primary_i,
  input wire logic secondary_i,
  input wire logic tx_serial_i,
  output logic recovery_o,
  output logic [1:0] driver_o
);

  typedef struct packed {
    logic rec;
    logic [1:0] drv;
  } spl_ch_state_t;

  spl_ch_state_t s;
  spl_ch_state_t next_s;

  // the recovery path and both drivers, one flop stage each
  always_comb begin
    next_s = s;
    if (loopback_i) begin
      next_s.rec = tx_serial_i; // external inputs ignored, see [R03] [R05]
    end else if (input_select_i) begin
      next_s.rec = primary_i; // see [R01]
    end else begin
      next_s.rec = secondary_i; // see [R02]
    end
    for (int k = 0; k < 2; k++) begin
      // a powered-down driver shows a steady low, see [R07]
      if (!driver_enable_i[k]) begin
        next_s.drv[k] = 1'b0;
      end else if (loopback_i) begin
        next_s.drv[k] = 1'b1; // see [R04]
      end else begin
        next_s.drv[k] = tx_serial_i;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign recovery_o = s.rec;
  assign driver_o = s.drv;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_sel_primary: assert property ( // see [R01]
    !loopback_i && input_select_i |=> recovery_o == $past(primary_i))
    else $error("primary input not passed to recovery");

  a_sel_secondary: assert property ( // see [R02]
    !loopback_i && !input_select_i |=> recovery_o == $past(secondary_i))
    else $error("secondary input not passed to recovery");

  a_loop_route: assert property ( // see [R03] [R05]
    loopback_i |=> recovery_o == $past(tx_serial_i))
    else $error("loopback did not route transmit data");

  a_loop_drv_one: assert property ( // see [R04]
    loopback_i && driver_enable_i[0] |=> driver_o[0])
    else $error("enabled driver not held at one in loopback");

  a_drv_off: assert property ( // see [R07]
    !driver_enable_i[1] |=> !driver_o[1])
    else $error("disabled driver still toggles");

endmodule

//--- spl_port_ctrl.sv
// serial port select, loopback and driver enable control, wishbone slave
//
// Function
// [R01] With its input select high a channel feeds its primary input to recovery.
// [R02] With its input select low a channel feeds its secondary input to recovery.
// [R03] Loopback routes each channel's transmit stream to its own recovery path.
// [R04] In loopback every enabled driver holds a steady one instead of data.
// [R05] In loopback both external serial inputs are ignored on every channel.
// [R06] While the latch is open the shared enable bus drives the driver enables.
// [R07] An enable bit high turns its driver on and a low bit powers it down.
// [R08] Closing the latch captures the last bus value and holds it until reopened.
// [R09] A sampled low device reset clears the latch, disabling every driver.
// [R10] The three-level amplitude select picks one of three detect thresholds.
// [R11] The device reset is sampled on the clock edge and needs one low edge.
// [R12] Each of the eight enable bits maps to one driver, two per channel.
`timescale 1ns/100ps
module spl_port_ctrl #(
  parameter logic [7:0] THR_LOW = spl_pkg::THR_LOW_DEF,
  parameter logic [7:0] THR_MID = spl_pkg::THR_MID_DEF,
  parameter logic [7:0] THR_HIGH = spl_pkg::THR_HIGH_DEF
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  input wire logic device_reset_n_i,
  input wire logic [3:0] primary_serial_input_i,
  input wire logic [3:0] secondary_serial_input_i,
  input wire logic [3:0] tx_serial_i,
  input wire logic [31:0] rx_amplitude_i,
  output logic [3:0] recovery_data_o,
  output logic [7:0] serial_driver_pair_o,
  output logic [7:0] driver_enable_o,
  output logic [3:0] signal_valid_o,
  output logic [7:0] detect_threshold_o
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic loop;
    logic [3:0] serial_input_select;
    logic open;
    logic [1:0] amp;
    logic [7:0] enbus;
    logic dev_rst;
    logic [3:0] valid;
    logic [7:0] thresh;
    logic [7:0] drv_en;
  } spl_top_state_t;

  spl_top_state_t s;
  spl_top_state_t next_s;

  logic req;
  logic wr;
  logic [31:0] ctrl_img;
  logic [31:0] ctrl_new;
  logic [31:0] enbus_new;
  logic [31:0] stat_img;

  spl_latch_if #(.W(spl_pkg::EN_W)) lif ();

  // ****************************************************************
  // byte lane merge
  // ****************************************************************
  // only lanes with their select bit set are replaced
  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] nw,
    input logic [3:0] sel
  );
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // ****************************************************************
  // register images
  // ****************************************************************
  // request seen once; ack in the next cycle closes it
  assign req = wb_cyc_i && wb_stb_i && !s.ack;
  assign wr = req && wb_we_i;

  always_comb begin
    ctrl_img = '0;
    ctrl_img[spl_pkg::CTRL_LOOP_BIT] = s.loop;
    ctrl_img[spl_pkg::CTRL_SEL_LSB +: spl_pkg::SEL_W] = s.serial_input_select;
    ctrl_img[spl_pkg::CTRL_OPEN_BIT] = s.open;
    ctrl_img[spl_pkg::CTRL_AMP_LSB +: 2] = s.amp;
  end

  assign ctrl_new = merge(ctrl_img, wb_dat_i, wb_sel_i);
  assign enbus_new = merge({24'h000000, s.enbus}, wb_dat_i, wb_sel_i);

  // status shows the live latch, reset sample and detect results
  always_comb begin
    stat_img = '0;
    stat_img[spl_pkg::EN_W-1:0] = lif.held;
    stat_img[spl_pkg::STAT_VALID_LSB +: spl_pkg::CHANNELS] = s.valid;
    stat_img[spl_pkg::STAT_RST_BIT] = s.dev_rst;
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    next_s = s;
    next_s.ack = req;
    next_s.rdata = '0;
    if (req && !wb_we_i) begin
      unique case (wb_adr_i)
        spl_pkg::CTRL_OFF: next_s.rdata = ctrl_img;
        spl_pkg::ENBUS_OFF: next_s.rdata = {24'h000000, s.enbus};
        spl_pkg::STAT_OFF: next_s.rdata = stat_img;
        default: next_s.rdata = '0; // unmapped reads answer zero
      endcase
    end
    if (wr && wb_adr_i == spl_pkg::CTRL_OFF) begin
      next_s.loop = ctrl_new[spl_pkg::CTRL_LOOP_BIT];
      next_s.serial_input_select =
        ctrl_new[spl_pkg::CTRL_SEL_LSB +: spl_pkg::SEL_W];
      next_s.open = ctrl_new[spl_pkg::CTRL_OPEN_BIT];
      next_s.amp = ctrl_new[spl_pkg::CTRL_AMP_LSB +: 2];
    end
    if (wr && wb_adr_i == spl_pkg::ENBUS_OFF) begin
      next_s.enbus = enbus_new[spl_pkg::EN_W-1:0];
    end
    // the reset pin is only looked at on the clock edge, see [R11]
    next_s.dev_rst = !device_reset_n_i;
    // illegal select code falls back to the middle trip point
    unique case (s.amp)
      spl_pkg::SPL_AMP_LOW: next_s.thresh = THR_LOW; // see [R10]
      spl_pkg::SPL_AMP_MID: next_s.thresh = THR_MID;
      spl_pkg::SPL_AMP_HIGH: next_s.thresh = THR_HIGH;
      default: next_s.thresh = THR_MID;
    endcase
    for (int c = 0; c < spl_pkg::CHANNELS; c++) begin
      next_s.valid[c] =
        rx_amplitude_i[c*spl_pkg::AMP_W +: spl_pkg::AMP_W] >= s.thresh;
    end
    next_s.drv_en = lif.held; // see [R07]
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
      s.serial_input_select <= spl_pkg::SEL_RST;
      s.amp <= spl_pkg::AMP_RST;
      s.enbus <= spl_pkg::ENBUS_RST;
      s.thresh <= THR_MID;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************************************
  // driver enable latch
  // ****************************************************************
  // latch clear comes straight from the pin level, not from the registered dev_rst sample
  assign lif.open = s.open;
  assign lif.bus = s.enbus;
  assign lif.clear = !device_reset_n_i; // see [R09] [R11]

  spl_enable_latch u_latch (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .lat(lif)
  );

  // ****************************************************************
  // channels
  // ****************************************************************
  // bits 2c and 2c+1 enable the primary and secondary driver, see [R12]
  for (genvar c = 0; c < spl_pkg::CHANNELS; c++) begin : g_ch
    spl_channel u_ch (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .input_select_i(s.serial_input_select[c]),
      .loopback_i(s.loop),
      .driver_enable_i(lif.held[c*spl_pkg::DRV_PER_CH +: 2]),
      .primary_i(primary_serial_input_i[c]),
      .secondary_i(secondary_serial_input_i[c]),
      .tx_serial_i(tx_serial_i[c]),
      .recovery_o(recovery_data_o[c]),
      .driver_o(serial_driver_pair_o[c*spl_pkg::DRV_PER_CH +: 2])
    );
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign wb_ack_o = s.ack;
  assign wb_dat_o = s.rdata;
  assign driver_enable_o = s.drv_en;
  assign signal_valid_o = s.valid;
  assign detect_threshold_o = s.thresh;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_one_cycle: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single cycle after the request");

  a_thresh_low: assert property ( // see [R10]
    s.amp == spl_pkg::SPL_AMP_LOW |=> detect_threshold_o == THR_LOW)
    else $error("low select gave wrong threshold");

  a_thresh_high: assert property ( // see [R10]
    s.amp == spl_pkg::SPL_AMP_HIGH |=> detect_threshold_o == THR_HIGH)
    else $error("high select gave wrong threshold");

  a_reset_clears: assert property ( // see [R09] [R11]
    !device_reset_n_i |=> ##1 driver_enable_o == '0)
    else $error("device reset left a driver enabled");

  a_enable_map: assert property ( // see [R12]
    driver_enable_o[0] == 1'b0 |-> serial_driver_pair_o[0] == 1'b0)
    else $error("driver zero runs while disabled");

  // ****************************************************************
  // checks across the submodules
  // ****************************************************************
  // the same rules seen from the top, so a wiring slip between the
  // registers, the latch and the channels is caught here as well

  a_thresh_mid: assert property ( // see [R10]
    s.amp == spl_pkg::SPL_AMP_MID |=> detect_threshold_o == THR_MID)
    else $error("mid select gave wrong threshold");

  // the unused fourth code must not leave the threshold undefined
  a_thresh_bad: assert property ( // see [R10]
    s.amp == 2'h3 |=> detect_threshold_o == THR_MID)
    else $error("unused select code gave wrong threshold");

  a_valid_first: assert property ( // see [R10]
    1'b1 |=> signal_valid_o[0] ==
      ($past(rx_amplitude_i[spl_pkg::AMP_W-1:0]) >= $past(s.thresh)))
    else $error("first channel valid flag disagrees with threshold");

  a_valid_last: assert property ( // see [R10]
    1'b1 |=> signal_valid_o[spl_pkg::CHANNELS-1] ==
      ($past(rx_amplitude_i[spl_pkg::CHANNELS*spl_pkg::AMP_W-1 -:
      spl_pkg::AMP_W]) >= $past(s.thresh)))
    else $error("last channel valid flag disagrees with threshold");

  a_enable_copy: assert property ( // see [R07]
    1'b1 |=> driver_enable_o == $past(lif.held))
    else $error("driver enables do not follow the latch");

  a_top_open: assert property ( // see [R06]
    s.open && device_reset_n_i |=> lif.held == $past(s.enbus))
    else $error("open latch did not pass the enable bus");

  a_top_closed: assert property ( // see [R08]
    !s.open && device_reset_n_i |=> $stable(lif.held))
    else $error("closed latch lost its captured value");

  a_top_clear: assert property ( // see [R09]
    !device_reset_n_i |=> lif.held == '0)
    else $error("sampled device reset did not clear the latch");

  a_reset_flag: assert property ( // see [R11]
    !device_reset_n_i |=> stat_img[spl_pkg::STAT_RST_BIT])
    else $error("sampled device reset not shown in status");

  a_loop_drv_held: assert property ( // see [R04]
    s.loop |=> serial_driver_pair_o == $past(lif.held))
    else $error("enabled drivers not held at one in loopback");

  a_off_drv_low: assert property ( // see [R07]
    1'b1 |=> (serial_driver_pair_o & ~$past(lif.held)) == '0)
    else $error("powered down driver not low");

  a_loop_recovery: assert property ( // see [R03] [R05]
    s.loop |=> recovery_data_o == $past(tx_serial_i))
    else $error("loopback did not feed transmit data to recovery");

  a_sel_mux: assert property ( // see [R01] [R02]
    !s.loop |=> recovery_data_o ==
      (($past(s.serial_input_select) & $past(primary_serial_input_i)) |
      (~$past(s.serial_input_select) & $past(secondary_serial_input_i))))
    else $error("input select did not pick the right serial input");

  // read data stays zero outside the acknowledge cycle
  a_rdata_idle: assert property (
    !wb_ack_o |-> wb_dat_o == '0)
    else $error("read data present without acknowledge");

endmodule

//--- spl_host_model.sv
// host side model: device reset driver and serial stream source
`timescale 1ns/100ps
module spl_host_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic reset_req_i,
  output logic device_reset_n_o,
  output logic [3:0] primary_o,
  output logic [3:0] secondary_o,
  output logic [3:0] tx_o
);
  logic [7:0] cnt = 8'h00;
  logic req_q = 1'b0;

  // ****************************************
  // serial streams
  // ****************************************
  // new bits every cycle, so a stale or wrong path never matches by luck
  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= 8'h00;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end

  // the two inputs of a channel always differ
  assign primary_o = cnt[3:0];
  assign secondary_o = ~cnt[3:0];
  assign tx_o = cnt[7:4] ^ {cnt[2:0], cnt[3]};

  // ****************************************
  // device reset
  // ****************************************
  // registered, so the low level always spans a whole clock edge
  always @(posedge clk_i) begin
    req_q <= reset_req_i;
  end
  assign device_reset_n_o = ~req_q;
endmodule

//--- tb.sv
// bench for the serial port select and driver enable block
`timescale 1ns/100ps
module tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic wb_we_i = 1'b0;
  logic [3:0] wb_sel_i = 4'h0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic [31:0] amp = 32'h0;
  logic rst_req = 1'b0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic dev_rst_n;
  logic [3:0] prim, sec, tx, rec, valid, pp, ps, pt;
  logic [7:0] drv, den, thr;
  logic loop_v = 1'b0;
  logic [3:0] sel_v = 4'hF;
  logic [7:0] en_v = 8'h00;
  int err_total = 0;
  int num_checks = 0;

  // ****************************************
  // clock, instances
  // ****************************************
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end

  spl_port_ctrl u_spl_port_ctrl (.clk_i(clk_i), .rst_i(rst_i),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .device_reset_n_i(dev_rst_n), .primary_serial_input_i(prim),
    .secondary_serial_input_i(sec), .tx_serial_i(tx),
    .rx_amplitude_i(amp), .recovery_data_o(rec),
    .serial_driver_pair_o(drv), .driver_enable_o(den),
    .signal_valid_o(valid), .detect_threshold_o(thr));

  spl_host_model u_spl_host_model (.clk_i(clk_i), .rst_i(rst_i),
    .reset_req_i(rst_req), .device_reset_n_o(dev_rst_n),
    .primary_o(prim), .secondary_o(sec), .tx_o(tx));

  // inputs as the block sampled them at the last edge
  always @(posedge clk_i) begin
    pp <= prim;
    ps <= sec;
    pt <= tx;
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // one classic cycle; entered just after a rising edge
  task automatic wb(input logic [7:0] a, input logic we,
                    input logic [31:0] d, input logic [3:0] s,
                    output logic [31:0] q);
    int n;
    n = 0;
    wb_adr_i <= a;
    wb_we_i <= we;
    wb_dat_i <= d;
    wb_sel_i <= s;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 50) begin
      err_total++;
      $display("unexpected at %0t: seen 0 expected 1 on ack", $time);
      results();
    end
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(a, 1'b1, d, 4'hF, q);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] e);
    logic [31:0] q;
    wb(a, 1'b0, 32'h0, 4'hF, q);
    chk(q & m, e);
  endtask

  function automatic logic [31:0] cw(logic l, logic [3:0] s, logic o,
                                     logic [1:0] a);
    cw = 32'h0;
    cw[spl_pkg::CTRL_LOOP_BIT] = l;
    cw[spl_pkg::CTRL_SEL_LSB +: 4] = s;
    cw[spl_pkg::CTRL_OPEN_BIT] = o;
    cw[spl_pkg::CTRL_AMP_LSB +: 2] = a;
  endfunction

  // compares the serial paths each cycle against the expected routing
  task automatic paths(input int n);
    logic [7:0] d;
    logic [3:0] r;
    repeat (n) begin
      @(negedge clk_i);
      r = loop_v ? pt : ((sel_v & pp) | (~sel_v & ps));
      for (int c = 0; c < 4; c++) begin
        d[2*c +: 2] = {2{loop_v | pt[c]}};
      end
      chk({28'h0, rec}, {28'h0, r});
      chk({24'h0, drv}, {24'h0, d & en_v});
      chk({24'h0, den}, {24'h0, en_v});
    end
    @(posedge clk_i);
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial begin
    logic [31:0] q;
    logic [7:0] t;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    // reset values, unmapped and misaligned places read zero
    rdc(8'h00, 32'hFFFFFFFF, cw(1'b0, 4'hF, 1'b0, 2'h1));
    rdc(spl_pkg::ENBUS_OFF, 32'hFFFFFFFF, 32'h0);
    rdc(spl_pkg::STAT_OFF, 32'h1FFF, 32'h0);
    rdc(8'h0C, 32'hFFFFFFFF, 32'h0);
    rdc(8'h01, 32'hFFFFFFFF, 32'h0);
    chk({24'h0, thr}, {24'h0, spl_pkg::THR_MID_DEF});
    paths(4);
    $display("test reset done");
    // input select per channel, both levels on every channel
    for (int i = 0; i < 3; i++) begin
      sel_v = (i == 0) ? 4'h5 : (i == 1) ? 4'hA : 4'h0;
      wr(spl_pkg::CTRL_OFF, cw(1'b0, sel_v, 1'b0, 2'h1));
      paths(8);
    end
    $display("test select done");
    // open latch follows the bus, closed latch holds
    wr(spl_pkg::ENBUS_OFF, 32'hA5);
    wr(spl_pkg::CTRL_OFF, cw(1'b0, sel_v, 1'b1, 2'h1));
    en_v = 8'hA5;
    repeat (2) @(posedge clk_i);
    paths(4);
    rdc(spl_pkg::STAT_OFF, 32'hFF, 32'hA5);
    wr(spl_pkg::ENBUS_OFF, 32'h3C);
    en_v = 8'h3C;
    repeat (2) @(posedge clk_i);
    paths(4);
    wr(spl_pkg::CTRL_OFF, cw(1'b0, sel_v, 1'b0, 2'h1));
    wr(spl_pkg::ENBUS_OFF, 32'hFF);
    wb(spl_pkg::ENBUS_OFF, 1'b1, 32'h0, 4'h0, q);
    wr(spl_pkg::STAT_OFF, 32'hFFFFFFFF);
    rdc(spl_pkg::ENBUS_OFF, 32'hFFFFFFFF, 32'hFF);
    rdc(spl_pkg::STAT_OFF, 32'hFF, 32'h3C);
    paths(6);
    $display("test latch done");
    // loopback with both select settings
    loop_v = 1'b1;
    for (int i = 0; i < 2; i++) begin
      sel_v = i[0] ? 4'hA : 4'h5;
      wr(spl_pkg::CTRL_OFF, cw(1'b1, sel_v, 1'b0, 2'h1));
      paths(8);
    end
    loop_v = 1'b0;
    wr(spl_pkg::CTRL_OFF, cw(1'b0, sel_v, 1'b0, 2'h1));
    $display("test loopback done");
    // one-edge device reset clears the closed latch only
    rst_req <= 1'b1;
    @(posedge clk_i);
    rst_req <= 1'b0;
    en_v = 8'h00;
    repeat (4) @(posedge clk_i);
    paths(4);
    rdc(spl_pkg::CTRL_OFF, 32'hFFFFFFFF, cw(1'b0, sel_v, 1'b0, 2'h1));
    wr(spl_pkg::CTRL_OFF, cw(1'b0, sel_v, 1'b1, 2'h1));
    en_v = 8'hFF;
    repeat (2) @(posedge clk_i);
    paths(4);
    $display("test device reset done");
    // every amplitude code, channels just below, at and above
    for (int a = 0; a < 4; a++) begin
      t = (a == 0) ? spl_pkg::THR_LOW_DEF : (a == 2) ?
        spl_pkg::THR_HIGH_DEF : spl_pkg::THR_MID_DEF;
      amp <= {8'h00, t + 8'h01, t, t - 8'h01};
      wr(spl_pkg::CTRL_OFF, cw(1'b0, sel_v, 1'b1, a[1:0]));
      repeat (3) @(posedge clk_i);
      // look between edges, where the registered outputs have settled
      @(negedge clk_i);
      chk({24'h0, thr}, {24'h0, t});
      chk({28'h0, valid}, 32'h6);
      @(posedge clk_i);
    end
    $display("test threshold done");
    results();
  end
endmodule
